// ==== sarcc_pkg.sv ====
/*
  Shared constants and carrier types for the SAR converter control block.
  Assumes a single 200 MHz system clock domain.
*/
package sarcc_pkg;
  localparam int unsigned RES_W = 10;
  localparam logic [9:0] FULL_SCALE = 10'h3FF;
  localparam logic [9:0] ZERO_CODE = 10'h000;
  localparam logic [9:0] SIGN_FLIP = 10'h200;
  localparam int unsigned CONV_CYCLES = 13;
  localparam int unsigned PIN_W = 8;

  // Register map, word addresses on the local port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CFG = 4'h1;
  localparam logic [3:0] ADDR_PINS = 4'h2;
  localparam logic [3:0] ADDR_RESULT = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;

  // Control register bit positions
  localparam int unsigned B_CORE_ON = 0;
  localparam int unsigned B_CONV_EN = 1;
  localparam int unsigned B_SW_START = 2;
  localparam int unsigned B_REF_ON = 3;
  localparam int unsigned B_REF_LVL = 4;
  localparam int unsigned B_REF_OUT = 5;
  localparam int unsigned B_REF_BURST = 6;
  localparam int unsigned B_TWOS = 7;

  // Clock sources
  localparam logic [1:0] SRC_OSC = 2'h0;
  localparam logic [1:0] SRC_AUX = 2'h1;
  localparam logic [1:0] SRC_MAIN = 2'h2;
  localparam logic [1:0] SRC_SUB = 2'h3;

  // Sample periods in conversion clock cycles
  localparam logic [6:0] SHT_0 = 7'h04;
  localparam logic [6:0] SHT_1 = 7'h08;
  localparam logic [6:0] SHT_2 = 7'h10;
  localparam logic [6:0] SHT_3 = 7'h40;

  typedef struct packed {
    logic [1:0] sample_time_select;
    logic [1:0] trigger_source_select;
    logic trigger_invert;
    logic reference_select_bit1;
    logic reference_select_bit0;
    logic [2:0] clock_divider;
    logic [1:0] clock_source_select;
  } sarcc_cfg_s;

  localparam sarcc_cfg_s CFG_RST = '0;

  typedef struct packed {
    logic core_power;
    logic osc_enable;
    logic bandgap_on;
    logic ref_buffer_on;
    logic ref_2v5;
    logic ext_ref_buffered;
  } sarcc_pwr_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SYNC = 4'b0010,
    ST_SAMP = 4'b0100,
    ST_CONV = 4'b1000
  } sarcc_state_e;
endpackage

// ==== sarcc_top.sv ====
/*
  Control logic of a 10-bit SAR converter: register port, clock source
  and divider, trigger select, sampling window, 13-cycle conversion,
  reference and auto power-down outputs, analog pin buffer disables.
  Assumes the analog SAR core returns a raw code on sar_code, and that
  clock sources and timer outputs are asynchronous pins.
*/
// Our own choices: strobed register access and the placing of the registers.
// Contract
// - Each finished 10-bit outcome lands in the result register.
// - Codes span 0 to 3FF, clamped at the references.
// - Results read straight binary or two's complement per config.
// - Core powered only while core power-on is set.
// - Most config bits change only while conversion enable is clear.
// - No conversion starts unless conversion enable is set.
// - Conversion clock from sub-main, main, auxiliary or oscillator.
// - Selected source divided by 1 to 8; it times sample and convert.
// - Analog pin enable disables that pin's input and output buffers.
// - Reference on enables reference; level 2.5 V or 1.5 V.
// - External reference buffered only when both select bits are 1.
// - Reference on, idle: buffer off, band-gap stays, buffer on when needed.
// - Reference output: burst 0 keeps buffer on, burst 1 only converting.
// - Core auto-disabled when idle, re-enabled on request.
// - Internal oscillator enabled only while needed.
// - Conversion begins on rising edge of sample-hold trigger.
// - Trigger from software start bit or timer outputs 0, 1, 2.
// - Trigger invert flips the selected source before edge detect.
// - Sample period 4, 8, 16 or 64 conversion clock cycles.
// - After sync, sampling window high for the selected period.
// - Conversion starts on window fall and takes 13 clock cycles.
`timescale 1ns/100ps
module sarcc_top #(
  parameter int unsigned PINS = sarcc_pkg::PIN_W
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic sub_main_clock,
  input wire logic aux_clock,
  input wire logic internal_conv_oscillator,
  input wire logic [2:0] timer_out,
  input wire logic [sarcc_pkg::RES_W-1:0] sar_code,
  output logic sar_conversion_clock,
  output logic sampling_window,
  output logic sar_convert,
  output logic busy,
  output sarcc_pkg::sarcc_pwr_s pwr,
  output logic [PINS-1:0] pin_in_buf_dis,
  output logic [PINS-1:0] pin_out_buf_dis
);
  import sarcc_pkg::*;

  // Register state
  logic [7:0] ctrl, next_ctrl;
  sarcc_cfg_s cfg, next_cfg;
  logic [PINS-1:0] analog_pin_enable, next_analog_pin_enable;
  logic [RES_W-1:0] conversion_result_reg, next_conversion_result_reg;
  logic twos_mode, next_twos_mode;
  logic [15:0] next_reg_rdata;

  // Source pin synchronisers
  logic [3:0] src_s1, src_s2;
  logic [2:0] tmr_s1, tmr_s2;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      src_s1 <= '0;
      src_s2 <= '0;
      tmr_s1 <= '0;
      tmr_s2 <= '0;
    end else begin
      src_s1 <= {sub_main_clock, 1'b0, aux_clock, internal_conv_oscillator};
      src_s2 <= src_s1;
      tmr_s1 <= timer_out;
      tmr_s2 <= tmr_s1;
    end
  end

  // Clock source selection and divider
  logic src_lvl, src_prev, next_src_prev;
  logic src_rise;
  logic [2:0] div_cnt, next_div_cnt;
  logic cclk, next_cclk;
  logic cclk_tick;
  logic main_tog, next_main_tog;

  always_comb begin
    next_main_tog = ~main_tog;
    case (cfg.clock_source_select)
      SRC_SUB: src_lvl = src_s2[3];
      SRC_MAIN: src_lvl = main_tog;
      SRC_AUX: src_lvl = src_s2[1];
      SRC_OSC: src_lvl = src_s2[0];
      default: src_lvl = 1'b0;
    endcase
    next_src_prev = src_lvl;
    src_rise = src_lvl & ~src_prev;
    next_div_cnt = div_cnt;
    // One mclk pulse per divided period, even when the factor is 1
    next_cclk = 1'b0;
    cclk_tick = 1'b0;
    if (src_rise) begin
      if (div_cnt == cfg.clock_divider) begin
        next_div_cnt = '0;
        cclk_tick = 1'b1;
        next_cclk = 1'b1;
      end else begin
        next_div_cnt = div_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      src_prev <= 1'b0;
      div_cnt <= '0;
      cclk <= 1'b0;
      main_tog <= 1'b0;
    end else begin
      src_prev <= next_src_prev;
      div_cnt <= next_div_cnt;
      cclk <= next_cclk;
      main_tog <= next_main_tog;
    end
  end

  assign sar_conversion_clock = cclk;

  // Trigger selection, polarity and edge
  logic trig_raw, trig_lvl, trig_prev, next_trig_prev;
  logic sample_hold_trigger_rise;

  always_comb begin
    case (cfg.trigger_source_select)
      2'h0: trig_raw = ctrl[B_SW_START];
      2'h1: trig_raw = tmr_s2[0];
      2'h2: trig_raw = tmr_s2[1];
      2'h3: trig_raw = tmr_s2[2];
      default: trig_raw = 1'b0;
    endcase
    trig_lvl = trig_raw ^ cfg.trigger_invert;
    next_trig_prev = trig_lvl;
    sample_hold_trigger_rise = trig_lvl & ~trig_prev;
  end

  // Sequencer
  sarcc_state_e state, next_state;
  logic [6:0] cnt, next_cnt;
  logic [6:0] samp_len;
  logic accept, done;

  always_comb begin
    case (cfg.sample_time_select)
      2'h0: samp_len = SHT_0;
      2'h1: samp_len = SHT_1;
      2'h2: samp_len = SHT_2;
      2'h3: samp_len = SHT_3;
      default: samp_len = SHT_0;
    endcase
    next_state = state;
    next_cnt = cnt;
    done = 1'b0;
    accept = 1'b0;
    case (state)
      ST_IDLE: begin
        if (sample_hold_trigger_rise && ctrl[B_CONV_EN] &&
            ctrl[B_CORE_ON]) begin
          accept = 1'b1;
          next_state = ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (cclk_tick) begin
          next_state = ST_SAMP;
          next_cnt = samp_len - 7'h01;
        end
      end
      ST_SAMP: begin
        if (cclk_tick) begin
          if (cnt == 7'h00) begin
            next_state = ST_CONV;
            next_cnt = 7'(CONV_CYCLES - 1);
          end else begin
            next_cnt = cnt - 7'h01;
          end
        end
      end
      ST_CONV: begin
        if (cclk_tick) begin
          if (cnt == 7'h00) begin
            done = 1'b1;
            next_state = ST_IDLE;
          end else begin
            next_cnt = cnt - 7'h01;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (!ctrl[B_CONV_EN] || !ctrl[B_CORE_ON]) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      cnt <= '0;
      trig_prev <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      trig_prev <= next_trig_prev;
    end
  end

  assign sampling_window = (state == ST_SAMP);
  assign sar_convert = (state == ST_CONV);
  assign busy = (state != ST_IDLE);

  // Power and reference control
  logic active;

  always_comb begin
    active = busy;
    pwr.core_power = ctrl[B_CORE_ON] & active;
    pwr.osc_enable = active && cfg.clock_source_select == SRC_OSC;
    pwr.bandgap_on = ctrl[B_REF_ON];
    pwr.ref_2v5 = ctrl[B_REF_LVL];
    pwr.ext_ref_buffered = cfg.reference_select_bit0 &
                           cfg.reference_select_bit1;
    if (ctrl[B_REF_OUT] && !ctrl[B_REF_BURST]) begin
      pwr.ref_buffer_on = ctrl[B_REF_ON];
    end else begin
      pwr.ref_buffer_on = (ctrl[B_REF_ON] | pwr.ext_ref_buffered) &
                          active;
    end
  end

  for (genvar i = 0; i < PINS; i++) begin : g_pin
    assign pin_in_buf_dis[i] = analog_pin_enable[i];
    assign pin_out_buf_dis[i] = analog_pin_enable[i];
  end

  // Register port
  logic wr_ctrl, wr_cfg, wr_pins;
  logic [RES_W-1:0] code_clamped;

  always_comb begin
    wr_ctrl = reg_wr && reg_addr == ADDR_CTRL;
    wr_cfg = reg_wr && reg_addr == ADDR_CFG;
    wr_pins = reg_wr && reg_addr == ADDR_PINS;
    next_ctrl = ctrl;
    next_cfg = cfg;
    next_analog_pin_enable = analog_pin_enable;
    next_twos_mode = twos_mode;
    next_conversion_result_reg = conversion_result_reg;
    if (wr_ctrl) begin
      // Enable, start, reference output and burst bits are always writable
      next_ctrl[B_CONV_EN] = reg_wdata[B_CONV_EN];
      next_ctrl[B_SW_START] = reg_wdata[B_SW_START];
      next_ctrl[B_REF_OUT] = reg_wdata[B_REF_OUT];
      next_ctrl[B_REF_BURST] = reg_wdata[B_REF_BURST];
      if (!ctrl[B_CONV_EN]) begin
        next_ctrl[B_CORE_ON] = reg_wdata[B_CORE_ON];
        next_ctrl[B_REF_ON] = reg_wdata[B_REF_ON];
        next_ctrl[B_REF_LVL] = reg_wdata[B_REF_LVL];
        next_ctrl[B_TWOS] = reg_wdata[B_TWOS];
        next_twos_mode = reg_wdata[B_TWOS];
      end
    end
    if (wr_cfg && !ctrl[B_CONV_EN]) begin
      next_cfg = sarcc_cfg_s'(reg_wdata[$bits(sarcc_cfg_s)-1:0]);
    end
    if (wr_pins) begin
      next_analog_pin_enable = reg_wdata[PINS-1:0];
    end
    // Software start self-clears once accepted
    if (accept && cfg.trigger_source_select == 2'h0) begin
      next_ctrl[B_SW_START] = 1'b0;
    end
    // Core already clamps at references
    code_clamped = sar_code;
    if (done) begin
      next_conversion_result_reg = twos_mode ? (code_clamped ^ SIGN_FLIP)
                                             : code_clamped;
    end
    next_reg_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: next_reg_rdata = {8'h00, ctrl};
        ADDR_CFG: next_reg_rdata = 16'(cfg);
        ADDR_PINS: next_reg_rdata = 16'(analog_pin_enable);
        ADDR_RESULT: next_reg_rdata = 16'(conversion_result_reg);
        ADDR_STATUS: next_reg_rdata = 16'({state, busy});
        default: next_reg_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= '0;
      cfg <= CFG_RST;
      analog_pin_enable <= '0;
      twos_mode <= 1'b0;
      conversion_result_reg <= ZERO_CODE;
      reg_rdata <= '0;
    end else begin
      ctrl <= next_ctrl;
      cfg <= next_cfg;
      analog_pin_enable <= next_analog_pin_enable;
      twos_mode <= next_twos_mode;
      conversion_result_reg <= next_conversion_result_reg;
      reg_rdata <= next_reg_rdata;
    end
  end
endmodule

// ==== sarcc_chk_sva.sv ====
/*
  Concurrent checks for sarcc_top, seeing only its ports.
  Assumes one clock domain; bound to every sarcc_top instance below.
*/
`timescale 1ns/100ps
module sarcc_chk #(
  parameter int unsigned PINS = sarcc_pkg::PIN_W
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic sar_conversion_clock,
  input wire logic sampling_window,
  input wire logic sar_convert,
  input wire logic busy,
  input wire sarcc_pkg::sarcc_pwr_s pwr,
  input wire logic [PINS-1:0] pin_in_buf_dis,
  input wire logic [PINS-1:0] pin_out_buf_dis
);
  import sarcc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [3:0] ticks;
  logic [3:0] next_ticks;
  // Divided ticks seen during the conversion phase
  always_comb begin
    next_ticks = ticks;
    if (!sar_convert)
      next_ticks = 4'h0;
    else if (sar_conversion_clock)
      next_ticks = ticks + 4'h1;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)
      ticks <= 4'h0;
    else
      ticks <= next_ticks;
  end
  AST_CONV_TICKS: assert property (
    $fell(sar_convert) |-> ticks == 4'hD)
    else $error("conversion phase not 13 ticks");
  AST_WIN_TO_CONV: assert property (
    $fell(sampling_window) |-> sar_convert)
    else $error("window fall did not start conversion");
  AST_PHASE_BUSY: assert property (
    sampling_window || sar_convert |-> busy)
    else $error("phase active without busy");
  AST_ONE_PHASE: assert property (!(sampling_window && sar_convert))
    else $error("sample and convert overlap");
  AST_SYNC_FIRST: assert property ($rose(busy) |-> !sampling_window)
    else $error("window opened without sync");
  AST_CORE_IDLE: assert property (pwr.core_power |-> busy)
    else $error("core powered while idle");
  AST_OSC_IDLE: assert property (pwr.osc_enable |-> busy)
    else $error("oscillator on while idle");
  // External reference may run the buffer with the band-gap off
  AST_BUF_BGAP: assert property (
    pwr.ref_buffer_on |-> pwr.bandgap_on || pwr.ext_ref_buffered)
    else $error("buffer on without band-gap");
  AST_RDATA_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  AST_PIN_BOTH: assert property (pin_in_buf_dis == pin_out_buf_dis)
    else $error("pin buffer disables differ");
  cover property ($fell(sar_convert));
  cover property ($rose(sampling_window) ##1 sampling_window);
  cover property (pwr.ref_buffer_on && !busy);
endmodule
bind sarcc_top sarcc_chk #(.PINS(PINS)) i_chk (.mclk, .sys_rst, .reg_rd,
  .reg_rdata,
  .sar_conversion_clock, .sampling_window, .sar_convert, .busy, .pwr,
  .pin_in_buf_dis, .pin_out_buf_dis);

// ==== sarcc_far_model.sv ====
/*
  Far side of the converter control: clock sources, timer outputs and
  the analog core's code. Assumes the bench sets timer levels and code.
*/
`timescale 1ns/100ps
module sarcc_far_model (
  input wire logic [2:0] timer_lvl,
  input wire logic [9:0] code_set,
  input wire logic sar_convert,
  output logic sub_main_clock,
  output logic aux_clock,
  output logic internal_conv_oscillator,
  output logic [2:0] timer_out,
  output logic [9:0] sar_code
);
  initial begin
    sub_main_clock = 1'b0;
    aux_clock = 1'b0;
    internal_conv_oscillator = 1'b0;
  end
  // Sources never pause, so no conversion is starved
  always #7 sub_main_clock = ~sub_main_clock;
  always #31 aux_clock = ~aux_clock;
  always #97 internal_conv_oscillator = ~internal_conv_oscillator;
  assign timer_out = timer_lvl;
  // Code only valid while converting
  assign sar_code = sar_convert ? code_set : ~code_set;
endmodule

// ==== sar_adc_sample_convert_control_tb.sv ====
/*
  Self-checking bench for sarcc_top with the far-side model.
  Assumes main clock is mclk/2 and the register map of sarcc_pkg.
*/
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module sar_adc_sample_convert_control_tb;
  import sarcc_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] timer_lvl = 3'h0;
  logic [9:0] code_set = 10'h000;
  logic [15:0] reg_rdata;
  logic sub_main_clock, aux_clock, internal_conv_oscillator;
  logic [2:0] timer_out;
  logic [9:0] sar_code;
  logic sar_conversion_clock, sampling_window, sar_convert, busy;
  sarcc_pwr_s pwr;
  logic [7:0] pin_in_buf_dis, pin_out_buf_dis;
  int mismatches = 0;
  int n_tests = 0;
  always #2.5 mclk = ~mclk;
  sarcc_top i_dut (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .sub_main_clock, .aux_clock,
    .internal_conv_oscillator, .timer_out, .sar_code,
    .sar_conversion_clock, .sampling_window, .sar_convert, .busy, .pwr,
    .pin_in_buf_dis, .pin_out_buf_dis);
  sarcc_far_model i_far (.timer_lvl, .code_set, .sar_convert,
    .sub_main_clock, .aux_clock, .internal_conv_oscillator, .timer_out,
    .sar_code);
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    q = reg_rdata;
  endtask
  // Cycles a phase stays high, sampled at falling edges
  task automatic span(input bit cv, output int n);
    int w;
    w = 0;
    n = 0;
    while ((cv ? sar_convert : sampling_window) !== 1'b1 && w < 3000) begin
      @(negedge mclk);
      w++;
    end
    while ((cv ? sar_convert : sampling_window) === 1'b1) begin
      @(negedge mclk);
      n++;
    end
  endtask
  task automatic conv(input logic [15:0] cfg, input logic [7:0] ctl,
      input logic [9:0] code, input int smp, input int per);
    logic [15:0] q;
    int n;
    wr(ADDR_CTRL, 16'h0000);
    code_set <= code;
    timer_lvl <= {3{cfg[7]}};
    wr(ADDR_CFG, cfg);
    wr(ADDR_CTRL, {8'h00, ctl | 8'h03});
    if (cfg[9:8] == 2'h0)
      wr(ADDR_CTRL, {8'h00, ctl | 8'h07});
    else
      timer_lvl[cfg[9:8] - 2'h1] <= ~cfg[7];
    span(1'b0, n);
    if (per > 0) `CHK(n, smp * per)
    span(1'b1, n);
    if (per > 0) `CHK(n, 13 * per)
    repeat (2) @(negedge mclk);
    `CHK(busy, 1'b0)
    rd(ADDR_RESULT, q);
    `CHK(q, {6'h00, ctl[7] ? code ^ SIGN_FLIP : code})
  endtask
  task automatic t_misc;
    logic [15:0] q;
    rd(ADDR_CTRL, q);
    `CHK(q, 16'h0000)
    rd(4'hF, q);
    `CHK(q, 16'h0000)
    wr(ADDR_CTRL, 16'h0005);
    repeat (8) @(negedge mclk);
    `CHK(busy, 1'b0)
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_CTRL, 16'h0006);
    repeat (8) @(negedge mclk);
    `CHK({busy, pwr.core_power}, 2'b00)
    wr(ADDR_CFG, 16'h0FFF);
    wr(ADDR_CTRL, 16'h00BB);
    rd(ADDR_CFG, q);
    `CHK(q, 16'h0000)
    rd(ADDR_CTRL, q);
    `CHK(q, 16'h0022)
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_CFG, 16'h0060);
    wr(ADDR_CTRL, 16'h0038);
    wr(ADDR_PINS, 16'h00A5);
    @(negedge mclk);
    `CHK(pwr.ext_ref_buffered, 1'b1)
    `CHK({pwr.bandgap_on, pwr.ref_2v5}, 2'b11)
    `CHK(pwr.ref_buffer_on, 1'b1)
    `CHK({pin_in_buf_dis, pin_out_buf_dis}, 16'hA5A5)
    wr(ADDR_CTRL, 16'h0078);
    @(negedge mclk);
    `CHK(pwr.ref_buffer_on, 1'b0)
    wr(ADDR_CTRL, 16'h0008);
    @(negedge mclk);
    `CHK({pwr.bandgap_on, pwr.ref_2v5, pwr.ref_buffer_on}, 3'b100)
  endtask
  // Second start while busy must not stretch or repeat the run
  task automatic t_busy;
    int n;
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_CFG, 16'h0C02);
    wr(ADDR_CTRL, 16'h0003);
    wr(ADDR_CTRL, 16'h0007);
    wr(ADDR_CTRL, 16'h0007);
    span(1'b0, n);
    `CHK(n, 128)
    span(1'b1, n);
    repeat (40) @(negedge mclk);
    `CHK({busy, sampling_window}, 2'b00)
  endtask
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    int sp[4];
    logic [9:0] cd[4];
    logic [1:0] srcs[3];
    sp = '{4, 8, 16, 64};
    cd = '{10'h3FF, 10'h000, 10'h155, 10'h2AA};
    srcs = '{SRC_OSC, SRC_AUX, SRC_SUB};
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    t_misc;
    t_busy;
    for (int s = 0; s < 4; s++) begin
      conv({4'h0, s[1:0], s[1:0], s[0], 2'b00, s[2:0], SRC_MAIN},
        {s[0], 7'h00}, cd[s], sp[s], 2 * (s + 1));
    end
    for (int i = 0; i < 3; i++) begin
      conv({14'h0000, srcs[i]}, 8'h80, 10'h1F0, 0, 0);
    end
    conclude;
  end
  initial begin
    #300000;
    mismatches++;
    conclude;
  end
endmodule
